/* File: sim/cfr_charger_cfg_sva.sv */
module cfr_charger_cfg_sva (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Sense inputs
	input wire logic vin_ok,
	input wire logic sys_below_bat,
	// Control outputs
	input wire logic charging_allowed,
	input wire logic charge_done,
	input wire logic charge_timer_expired,
	input wire logic battery_monitor_active,
	input wire logic thermistor_source_on,
	input wire logic regulator_on,
	input wire logic isolation_closed,
	input wire logic chip_disable,
	input wire logic ideal_diode_on
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	bmon_valid_on_a: assert property (vin_ok |=> battery_monitor_active)
		else $error("monitor off with valid input");
	thr_valid_on_a: assert property (vin_ok |=> thermistor_source_on)
		else $error("source off with valid input");
	iso_open_chg_a: assert property (!regulator_on && charging_allowed && $past(charging_allowed) |-> !isolation_closed)
		else $error("isolation closed while charging");
	diode_needs_sys_a: assert property (ideal_diode_on |-> $past(sys_below_bat))
		else $error("diode on without cause");
	expiry_stops_chg_a: assert property ($rose(charge_timer_expired) |-> ##[1:2] !charging_allowed)
		else $error("charging after expiry");
	done_stops_chg_a: assert property (charge_done |=> !charging_allowed)
		else $error("charging after end of charge");
	dis_stops_chg_a: assert property (chip_disable |=> !charging_allowed)
		else $error("charging while disabled");
	chg_rise_cause_a: assert property ($rose(charging_allowed) |-> !$past(chip_disable) && !$past(charge_done))
		else $error("charging rose without cause");
endmodule : cfr_charger_cfg_sva

bind cfr_charger_cfg cfr_charger_cfg_sva chk (.sys_clk, .rst, .vin_ok, .sys_below_bat, .charging_allowed,
	.charge_done, .charge_timer_expired, .battery_monitor_active, .thermistor_source_on, .regulator_on,
	.isolation_closed, .chip_disable, .ideal_diode_on);

/* File: sim/cfr_charger_cfg_tb.sv */
module cfr_charger_cfg_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TK = 10;
	localparam int MSS = 1;
	localparam int TEND = 50;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic vin_ok, bat_above_weak, bat_below_vlim, sys_below_bat, in_trickle, in_fast, eoc_detect;
	logic sda_out, sda_oe_n, charging_allowed, charge_done, charge_timer_expired, watchdog_alarm, watchdog_fault;
	logic battery_monitor_active, thermistor_source_on, regulator_on, isolation_closed, chip_disable;
	logic ideal_diode_on, temp_compliance_active, temp_profile_sel;
	logic [2:0] system_voltage_code;
	logic [7:0] q;
	wire scl_in;
	wire host_sda;
	wire sda_in = host_sda & (sda_oe_n | sda_out);
	int failures = 0;
	int n_checks = 0;
	int cycles = 0;
	always #2.5 sys_clk = ~sys_clk;
	cfr_host_model host (.sys_clk(sys_clk), .sda_line(sda_in), .scl(scl_in), .sda(host_sda));
	cfr_charger_cfg #(.TICK_CYCLES(TK), .TEND_MS(TEND), .MS_PER_S(MSS)) uut (.sys_clk, .rst, .scl_in, .sda_in,
		.sda_out, .sda_oe_n, .vin_ok, .bat_above_weak, .bat_below_vlim, .sys_below_bat, .in_trickle, .in_fast,
		.eoc_detect, .charging_allowed, .charge_done, .charge_timer_expired, .watchdog_alarm, .watchdog_fault,
		.battery_monitor_active, .thermistor_source_on, .regulator_on, .isolation_closed, .chip_disable,
		.ideal_diode_on, .temp_compliance_active, .temp_profile_sel, .system_voltage_code);
	task automatic complete_run;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : complete_run
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		host.rd(a, q);
		chk(q, exp);
	endtask : rchk
	task automatic wset(input logic [7:0] a, input logic [7:0] d);
		host.wr(a, d);
		repeat (3) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask : wset
	// Cycles until a status output sets, judged against a window
	task automatic wait_set(input int sel, input int lo, input int hi);
		logic s;
		int n;
		n = 0;
		s = 1'b0;
		while (s !== 1'b1 && n < hi) begin
			@(negedge sys_clk);
			n++;
			s = sel == 0 ? charge_timer_expired : sel == 1 ? charge_done : sel == 2 ? watchdog_alarm : watchdog_fault;
		end
		chk({7'h0, n >= lo && s === 1'b1}, 8'h01);
	endtask : wait_set
	task automatic t_reset;
		rchk(8'h06, 8'h38);
		rchk(8'h07, 8'h04);
		rchk(8'h08, 8'h00);
		rchk(8'h09, 8'h00);
		chk({6'h0, regulator_on, charging_allowed}, 8'h02);
	endtask : t_reset
	task automatic t_fields;
		logic [7:0] d;
		wset(8'h06, 8'hFF);
		rchk(8'h06, 8'h3E);
		wset(8'h07, 8'hFF);
		rchk(8'h07, 8'h7D);
		wset(8'h07, 8'h04);
		wset(8'h06, 8'h38);
		for (int i = 0; i < 8; i++) begin
			d = {i[0], i[1], 3'h0, i[2:0]};
			wset(8'h08, d);
			chk({temp_compliance_active, temp_profile_sel, 3'h0, system_voltage_code}, d);
			rchk(8'h08, d);
		end
	endtask : t_fields
	task automatic t_diode;
		for (int k = 0; k < 16; k++) begin
			@(posedge sys_clk);
			{sys_below_bat, bat_above_weak} <= {k[3], k[0]};
			wset(8'h08, {3'h0, k[2:1], 3'h0});
			chk({7'h0, ideal_diode_on}, {7'h0, k[3] && (k[2:1] == 2'h0 || (k[2:1] == 2'h1 && k[0]))});
		end
	endtask : t_diode
	task automatic t_monitor;
		for (int k = 0; k < 8; k++) begin
			@(posedge sys_clk);
			vin_ok <= k[2];
			wset(8'h07, {2'h0, k[1], k[0], 4'h0});
			chk({6'h0, battery_monitor_active, thermistor_source_on}, {6'h0, k[2] | k[1], k[2] | k[0]});
		end
	endtask : t_monitor
	task automatic t_power;
		for (int k = 0; k < 2; k++) begin
			wset(8'h07, {7'h04, k[0]});
			chk({5'h0, regulator_on, isolation_closed, charging_allowed}, {6'h0, !k[0], k[0]});
		end
		wset(8'h07, 8'h49);
		chk({6'h0, chip_disable, charging_allowed}, 8'h02);
		wset(8'h07, 8'h01);
		for (int k = 0; k < 2; k++) begin
			@(posedge sys_clk);
			bat_below_vlim <= k[0];
			wset(8'h08, 8'h20);
			chk({7'h0, charging_allowed}, {7'h0, k[0]});
		end
		wset(8'h08, 8'h00);
	endtask : t_power
	task automatic t_trickle;
		wset(8'h06, 8'h20);
		@(posedge sys_clk);
		in_trickle <= 1'b1;
		repeat (800) @(posedge sys_clk);
		@(negedge sys_clk);
		chk({7'h0, charge_timer_expired}, 8'h00);
		for (int k = 0; k < 2; k++) begin
			@(posedge sys_clk);
			in_trickle <= 1'b0;
			wset(8'h06, {4'h3, k[0], 3'h0});
			@(posedge sys_clk);
			in_trickle <= 1'b1;
			wait_set(0, (k ? 60 : 30) * MSS * TK - 15, (k ? 60 : 30) * MSS * TK + 15);
		end
		@(posedge sys_clk);
		in_trickle <= 1'b0;
	endtask : t_trickle
	task automatic t_eoc;
		for (int k = 0; k < 3; k++) begin
			@(posedge sys_clk);
			eoc_detect <= 1'b0;
			wset(8'h07, 8'h00);
			wset(8'h06, k == 0 ? 8'h00 : 8'h20);
			wset(8'h07, k == 2 ? 8'h01 : 8'h05);
			@(posedge sys_clk);
			eoc_detect <= 1'b1;
			if (k < 2)
				wait_set(1, (k ? TEND : 31) * TK - 15, (k ? TEND : 31) * TK + 15);
		end
		repeat (800) @(posedge sys_clk);
		@(negedge sys_clk);
		chk({7'h0, charge_done}, 8'h00);
	endtask : t_eoc
	task automatic t_watchdog;
		wset(8'h06, 8'h00);
		repeat (800) @(posedge sys_clk);
		@(negedge sys_clk);
		chk({7'h0, watchdog_alarm}, 8'h00);
		for (int k = 0; k < 2; k++) begin
			host.wr(8'h06, {6'h01, k[0], 1'b1});
			wait_set(2, (k ? 64 : 32) * MSS * TK - 45, (k ? 64 : 32) * MSS * TK + 15);
		end
		// Safety timer follows the alarm and then blocks charging
		wait_set(3, 40 * 60 * MSS * TK - 15, 40 * 60 * MSS * TK + 15);
		repeat (2) @(negedge sys_clk);
		chk({7'h0, charging_allowed}, 8'h00);
	endtask : t_watchdog
	initial begin
		{vin_ok, bat_above_weak, bat_below_vlim, sys_below_bat, in_trickle, in_fast, eoc_detect} = 7'h00;
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		t_reset();
		t_fields();
		t_diode();
		t_monitor();
		t_power();
		t_trickle();
		t_eoc();
		t_watchdog();
		complete_run();
	end
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 90000) begin
			failures++;
			complete_run();
		end
	end
endmodule : cfr_charger_cfg_tb

/* File: sim/cfr_host_model.sv */
module cfr_host_model #(
	parameter logic [6:0] DEV_ADDR = 7'h14
) (
	// Clock
	input wire logic sys_clk,
	// Two-wire bus
	input wire logic sda_line,
	output logic scl,
	output logic sda
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		scl = 1'b1;
		sda = 1'b1;
	end
	task automatic hc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : hc
	task automatic start;
		hc(1);
		sda <= 1'b1;
		hc(2);
		scl <= 1'b1;
		hc(4);
		sda <= 1'b0;
		hc(4);
		scl <= 1'b0;
		hc(1);
	endtask : start
	task automatic stop;
		sda <= 1'b0;
		hc(4);
		scl <= 1'b1;
		hc(4);
		sda <= 1'b1;
		hc(4);
	endtask : stop
	// Eight bits MSB first, then the acknowledge bit
	task automatic xfer(input logic [7:0] d, input logic ack, output logic [7:0] r);
		for (int i = 8; i >= 0; i--) begin
			sda <= i > 0 ? d[i-1] : ack;
			hc(4);
			scl <= 1'b1;
			hc(2);
			if (i > 0) r[i-1] = sda_line;
			hc(2);
			scl <= 1'b0;
			hc(1);
		end
	endtask : xfer
	// A one in bit 0 of the timer register restarts the watchdog
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] r;
		start();
		xfer({DEV_ADDR, 1'b0}, 1'b1, r);
		xfer(a, 1'b1, r);
		xfer(d, 1'b1, r);
		stop();
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] r);
		start();
		xfer({DEV_ADDR, 1'b0}, 1'b1, r);
		xfer(a, 1'b1, r);
		start();
		xfer({DEV_ADDR, 1'b1}, 1'b1, r);
		xfer(8'hFF, 1'b1, r);
		stop();
	endtask : rd
endmodule : cfr_host_model

/* File: verilog/cfr_charger_cfg.sv */
`include "cfr_consts.svh"

module cfr_charger_cfg #(
	parameter logic [6:0] DEV_ADDR = 7'h14,
	parameter logic [2:0] SYS_V_RESET = 3'h0,
	parameter int TICK_CYCLES = `CFR_NS_PER_MS / `CFR_CLK_PERIOD_NS,
	parameter int TEND_MS = 1000,
	parameter int MS_PER_S = `CFR_MS_PER_S
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Two-wire bus
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	// Analog sense
	input wire logic vin_ok,
	input wire logic bat_above_weak,
	input wire logic bat_below_vlim,
	input wire logic sys_below_bat,
	input wire logic in_trickle,
	input wire logic in_fast,
	input wire logic eoc_detect,
	// Control outputs
	output logic charging_allowed,
	output logic charge_done,
	output logic charge_timer_expired,
	output logic watchdog_alarm,
	output logic watchdog_fault,
	output logic battery_monitor_active,
	output logic thermistor_source_on,
	output logic regulator_on,
	output logic isolation_closed,
	output logic chip_disable,
	output logic ideal_diode_on,
	output logic temp_compliance_active,
	output logic temp_profile_sel,
	output logic [2:0] system_voltage_code
);
	localparam int TW = `CFR_TMR_W;
	localparam int TICK_W = $clog2(TICK_CYCLES + 1);
	localparam int MS_PER_MIN = MS_PER_S * `CFR_S_PER_MIN;

	typedef struct packed {
		logic [7:0] timer_settings;
		logic [7:0] functional_settings_one;
		logic [7:0] functional_settings_two;
		logic [TICK_W-1:0] tick_cnt;
		logic ms_tick;
		logic watchdog_restart;
		logic [1:0] last_phase;
		logic charge_done;
		logic charging_allowed;
		logic battery_monitor_active;
		logic thermistor_source_on;
		logic regulator_on;
		logic isolation_closed;
		logic ideal_diode_on;
	} cfr_main_t;

	cfr_main_t s;
	cfr_main_t n;
	cfr_reg_if regs ();

	logic eoc_expired;
	logic chg_expired;
	logic wd_expired;
	logic wd_safe_expired;
	logic [TW-1:0] eoc_limit;
	logic [TW-1:0] chg_limit;
	logic [TW-1:0] wd_limit;
	logic [1:0] phase;
	logic charging_on;
	logic eoc_run;
	logic chg_run;
	logic chg_clear;
	logic wd_clear;

	function automatic logic [TW-1:0] ms_of(input int count, input int unit_ms);
		ms_of = TW'(count * unit_ms);
	endfunction : ms_of

	function automatic logic [7:0] reg_read(input logic [7:0] addr, input cfr_main_t st);
		unique case (addr)
			`CFR_ADDR_TIMER: reg_read = st.timer_settings & `CFR_MASK_TIMER;
			`CFR_ADDR_FUNC1: reg_read = st.functional_settings_one & `CFR_MASK_FUNC1;
			`CFR_ADDR_FUNC2: reg_read = st.functional_settings_two;
			default: reg_read = 8'h00;
		endcase
	endfunction : reg_read

	cfr_i2c_slave #(
		.DEV_ADDR(DEV_ADDR)
	) u_serial (
		.sys_clk(sys_clk),
		.rst(rst),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.sda_oe_n(sda_oe_n),
		.regs(regs.serial_end)
	);

	assign regs.rd_data = reg_read(regs.rd_addr, s);
	assign charging_on = s.functional_settings_one[`CFR_F1_CHG_ON];
	assign phase = {in_fast, in_trickle && !in_fast};

	// End of charge, deglitch only when the long timer is off
	assign eoc_limit = s.timer_settings[`CFR_TS_TEND_ON] ? TW'(TEND_MS) : TW'(`CFR_DEGLITCH_MS);
	assign eoc_run = eoc_detect && charging_on && s.functional_settings_one[`CFR_F1_EOC_PERMIT];

	cfr_timer u_eoc (
		.sys_clk(sys_clk),
		.rst(rst),
		.tick(s.ms_tick),
		.run(eoc_run),
		.clear(!eoc_run),
		.limit(eoc_limit),
		.expired(eoc_expired)
	);

	// Trickle and fast safety timer
	always_comb begin
		if (in_fast) begin
			chg_limit = s.timer_settings[`CFR_TS_LEN_SEL] ? ms_of(`CFR_FAST_LONG_MIN, MS_PER_MIN)
				: ms_of(`CFR_FAST_SHORT_MIN, MS_PER_MIN);
		end else begin
			chg_limit = s.timer_settings[`CFR_TS_LEN_SEL] ? ms_of(`CFR_TRK_LONG_S, MS_PER_S)
				: ms_of(`CFR_TRK_SHORT_S, MS_PER_S);
		end
	end
	assign chg_run = s.timer_settings[`CFR_TS_SAFE_ON] && (in_trickle || in_fast);
	assign chg_clear = !charging_on || (phase != s.last_phase);

	cfr_timer u_chg (
		.sys_clk(sys_clk),
		.rst(rst),
		.tick(s.ms_tick),
		.run(chg_run),
		.clear(chg_clear),
		.limit(chg_limit),
		.expired(chg_expired)
	);

	// Watchdog interval then its safety timer
	assign wd_limit = s.timer_settings[`CFR_TS_WD_LEN] ? ms_of(`CFR_WD_LONG_S, MS_PER_S)
		: ms_of(`CFR_WD_SHORT_S, MS_PER_S);
	assign wd_clear = s.watchdog_restart || !s.timer_settings[`CFR_TS_WD_ON];

	cfr_timer u_wd (
		.sys_clk(sys_clk),
		.rst(rst),
		.tick(s.ms_tick),
		.run(s.timer_settings[`CFR_TS_WD_ON]),
		.clear(wd_clear),
		.limit(wd_limit),
		.expired(wd_expired)
	);

	cfr_timer u_wd_safe (
		.sys_clk(sys_clk),
		.rst(rst),
		.tick(s.ms_tick),
		.run(wd_expired),
		.clear(wd_clear),
		.limit(ms_of(`CFR_WD_SAFE_MIN, MS_PER_MIN)),
		.expired(wd_safe_expired)
	);

	always_comb begin
		n = s;
		n.watchdog_restart = 1'b0;
		n.last_phase = phase;
		// Millisecond enable
		if (s.tick_cnt == TICK_W'(TICK_CYCLES - 1)) begin
			n.tick_cnt = '0;
			n.ms_tick = 1'b1;
		end else begin
			n.tick_cnt = s.tick_cnt + TICK_W'(1);
			n.ms_tick = 1'b0;
		end
		// Register writes
		if (regs.wr_stb) begin
			unique case (regs.wr_addr)
				`CFR_ADDR_TIMER: begin
					n.timer_settings = regs.wr_data & `CFR_MASK_TIMER;
					n.watchdog_restart = regs.wr_data[`CFR_TS_WD_RESTART];
				end
				`CFR_ADDR_FUNC1: n.functional_settings_one = regs.wr_data & `CFR_MASK_FUNC1;
				`CFR_ADDR_FUNC2: n.functional_settings_two = regs.wr_data;
				default: begin
				end
			endcase
		end
		// Completion latches until charging is switched off
		if (!charging_on) begin
			n.charge_done = 1'b0;
		end else if (eoc_expired) begin
			n.charge_done = 1'b1;
		end
		n.charging_allowed = charging_on && !s.functional_settings_one[`CFR_F1_CHIP_DIS]
			&& !(s.functional_settings_two[`CFR_F2_VLIM_ON] && !bat_below_vlim)
			&& !chg_expired && !s.charge_done && !wd_safe_expired;
		n.battery_monitor_active = vin_ok || s.functional_settings_one[`CFR_F1_BMON_OVR];
		n.thermistor_source_on = vin_ok || s.functional_settings_one[`CFR_F1_THR_OVR];
		n.regulator_on = !s.functional_settings_one[`CFR_F1_REG_OFF];
		n.isolation_closed = s.functional_settings_one[`CFR_F1_REG_OFF] ? !charging_on : 1'b1;
		unique case (s.functional_settings_two[`CFR_F2_DIODE_HI:`CFR_F2_DIODE_LO])
			`CFR_DIODE_ALWAYS: n.ideal_diode_on = sys_below_bat;
			`CFR_DIODE_WEAK: n.ideal_diode_on = sys_below_bat && bat_above_weak;
			default: n.ideal_diode_on = 1'b0;
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s <= '0;
			s.timer_settings <= `CFR_RST_TIMER;
			s.functional_settings_one <= `CFR_RST_FUNC1;
			s.functional_settings_two <= {`CFR_RST_FUNC2_HI, SYS_V_RESET};
			s.regulator_on <= 1'b1;
			s.isolation_closed <= 1'b1;
		end else begin
			s <= n;
		end
	end

	assign sda_out = 1'b0;
	assign charging_allowed = s.charging_allowed;
	assign charge_done = s.charge_done;
	assign charge_timer_expired = chg_expired;
	assign watchdog_alarm = wd_expired;
	assign watchdog_fault = wd_safe_expired;
	assign battery_monitor_active = s.battery_monitor_active;
	assign thermistor_source_on = s.thermistor_source_on;
	assign regulator_on = s.regulator_on;
	assign isolation_closed = s.isolation_closed;
	assign chip_disable = s.functional_settings_one[`CFR_F1_CHIP_DIS];
	assign ideal_diode_on = s.ideal_diode_on;
	assign temp_compliance_active = s.functional_settings_two[`CFR_F2_TEMP_ON];
	assign temp_profile_sel = s.functional_settings_two[`CFR_F2_PROFILE];
	assign system_voltage_code = s.functional_settings_two[`CFR_F2_SYSV_HI:`CFR_F2_SYSV_LO];
endmodule : cfr_charger_cfg

/* File: verilog/cfr_consts.svh */
`ifndef CFR_CONSTS_SVH
`define CFR_CONSTS_SVH

// Register offsets
`define CFR_ADDR_TIMER 8'h06
`define CFR_ADDR_FUNC1 8'h07
`define CFR_ADDR_FUNC2 8'h08

// Writable masks, unused positions read zero
`define CFR_MASK_TIMER 8'h3E
`define CFR_MASK_FUNC1 8'h7D
`define CFR_MASK_FUNC2 8'hFF

// Reset values
`define CFR_RST_TIMER 8'h38
`define CFR_RST_FUNC1 8'h04
`define CFR_RST_FUNC2_HI 5'h00

// Timer settings fields
`define CFR_TS_TEND_ON 5
`define CFR_TS_SAFE_ON 4
`define CFR_TS_LEN_SEL 3
`define CFR_TS_WD_ON 2
`define CFR_TS_WD_LEN 1
`define CFR_TS_WD_RESTART 0

// Functional settings one fields
`define CFR_F1_CHIP_DIS 6
`define CFR_F1_BMON_OVR 5
`define CFR_F1_THR_OVR 4
`define CFR_F1_REG_OFF 3
`define CFR_F1_EOC_PERMIT 2
`define CFR_F1_CHG_ON 0

// Functional settings two fields
`define CFR_F2_TEMP_ON 7
`define CFR_F2_PROFILE 6
`define CFR_F2_VLIM_ON 5
`define CFR_F2_DIODE_HI 4
`define CFR_F2_DIODE_LO 3
`define CFR_F2_SYSV_HI 2
`define CFR_F2_SYSV_LO 0

// Ideal diode codes
`define CFR_DIODE_ALWAYS 2'h0
`define CFR_DIODE_WEAK 2'h1

// Times in their own units
`define CFR_CLK_PERIOD_NS 5
`define CFR_NS_PER_MS 1000000
`define CFR_MS_PER_S 1000
`define CFR_S_PER_MIN 60
`define CFR_DEGLITCH_MS 31
`define CFR_TRK_SHORT_S 30
`define CFR_TRK_LONG_S 60
`define CFR_FAST_SHORT_MIN 300
`define CFR_FAST_LONG_MIN 600
`define CFR_WD_SHORT_S 32
`define CFR_WD_LONG_S 64
`define CFR_WD_SAFE_MIN 40

// Timer counter width, in milliseconds
`define CFR_TMR_W 26

`endif

/* File: verilog/cfr_i2c_slave.sv */
module cfr_i2c_slave #(
	parameter logic [6:0] DEV_ADDR = 7'h14
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Two-wire bus
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_oe_n,
	// Register side
	cfr_reg_if.serial_end regs
);
	cfr_pkg::cfr_i2c_t s;
	cfr_pkg::cfr_i2c_t n;
	logic rise;
	logic fall;
	logic start_c;
	logic stop_c;
	logic [7:0] byte_in;

	assign rise = scl_in && !s.scl_q;
	assign fall = !scl_in && s.scl_q;
	assign start_c = s.scl_q && scl_in && s.sda_q && !sda_in;
	assign stop_c = s.scl_q && scl_in && !s.sda_q && sda_in;
	assign byte_in = {s.shreg[6:0], sda_in};

	always_comb begin
		n = s;
		n.scl_q = scl_in;
		n.sda_q = sda_in;
		n.wr_stb = 1'b0;
		if (start_c) begin
			n.state = cfr_pkg::CFR_I2C_ADDR;
			n.bitcnt = 3'h0;
			n.sda_drive = 1'b0;
			n.ack_phase = 1'b0;
		end else if (stop_c) begin
			n.state = cfr_pkg::CFR_I2C_IDLE;
			n.sda_drive = 1'b0;
		end else begin
			unique case (s.state)
				cfr_pkg::CFR_I2C_IDLE: begin
				end
				cfr_pkg::CFR_I2C_ADDR: begin
					if (rise) begin
						n.shreg = byte_in;
						n.bitcnt = s.bitcnt + 3'h1;
						if (s.bitcnt == 3'h7) begin
							n.rw = byte_in[0];
							n.state = (byte_in[7:1] == DEV_ADDR) ? cfr_pkg::CFR_I2C_ACK_A : cfr_pkg::CFR_I2C_IDLE;
						end
					end
				end
				cfr_pkg::CFR_I2C_ACK_A: begin
					if (fall) begin
						if (!s.ack_phase) begin
							n.sda_drive = 1'b1;
							n.ack_phase = 1'b1;
						end else begin
							n.ack_phase = 1'b0;
							n.bitcnt = 3'h0;
							if (s.rw) begin
								n.state = cfr_pkg::CFR_I2C_READ;
								n.shreg = regs.rd_data;
								n.sda_drive = !regs.rd_data[7];
							end else begin
								n.state = cfr_pkg::CFR_I2C_WRITE;
								n.sda_drive = 1'b0;
								n.first = 1'b1;
							end
						end
					end
				end
				cfr_pkg::CFR_I2C_WRITE: begin
					if (rise) begin
						n.shreg = byte_in;
						n.bitcnt = s.bitcnt + 3'h1;
						if (s.bitcnt == 3'h7) begin
							n.state = cfr_pkg::CFR_I2C_ACK_W;
							if (s.first) begin
								n.ptr = byte_in;
								n.first = 1'b0;
							end else begin
								n.wr_stb = 1'b1;
								n.wr_addr = s.ptr;
								n.wr_data = byte_in;
								n.ptr = s.ptr + 8'h01;
							end
						end
					end
				end
				cfr_pkg::CFR_I2C_ACK_W: begin
					if (fall) begin
						if (!s.ack_phase) begin
							n.sda_drive = 1'b1;
							n.ack_phase = 1'b1;
						end else begin
							n.sda_drive = 1'b0;
							n.ack_phase = 1'b0;
							n.state = cfr_pkg::CFR_I2C_WRITE;
						end
					end
				end
				cfr_pkg::CFR_I2C_READ: begin
					if (fall) begin
						n.bitcnt = s.bitcnt + 3'h1;
						if (s.bitcnt == 3'h7) begin
							n.sda_drive = 1'b0;
							n.ptr = s.ptr + 8'h01;
							n.state = cfr_pkg::CFR_I2C_ACK_R;
						end else begin
							n.shreg = {s.shreg[6:0], 1'b0};
							n.sda_drive = !s.shreg[6];
						end
					end
				end
				cfr_pkg::CFR_I2C_ACK_R: begin
					if (rise) begin
						n.state = sda_in ? cfr_pkg::CFR_I2C_IDLE : cfr_pkg::CFR_I2C_RD_NEXT;
					end
				end
				cfr_pkg::CFR_I2C_RD_NEXT: begin
					if (fall) begin
						n.bitcnt = 3'h0;
						n.shreg = regs.rd_data;
						n.sda_drive = !regs.rd_data[7];
						n.state = cfr_pkg::CFR_I2C_READ;
					end
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s <= '{state: cfr_pkg::CFR_I2C_IDLE, scl_q: 1'b1, sda_q: 1'b1, default: '0};
		end else begin
			s <= n;
		end
	end

	assign sda_oe_n = !s.sda_drive;
	assign regs.wr_stb = s.wr_stb;
	assign regs.wr_addr = s.wr_addr;
	assign regs.wr_data = s.wr_data;
	assign regs.rd_addr = s.ptr;
endmodule : cfr_i2c_slave

/* File: verilog/cfr_pkg.sv */
`include "cfr_consts.svh"

package cfr_pkg;

	typedef enum logic [2:0] {
		CFR_I2C_IDLE = 3'h0,
		CFR_I2C_ADDR = 3'h1,
		CFR_I2C_ACK_A = 3'h2,
		CFR_I2C_WRITE = 3'h3,
		CFR_I2C_ACK_W = 3'h4,
		CFR_I2C_READ = 3'h5,
		CFR_I2C_ACK_R = 3'h6,
		CFR_I2C_RD_NEXT = 3'h7
	} cfr_i2c_state_t;

	typedef struct packed {
		cfr_i2c_state_t state;
		logic [2:0] bitcnt;
		logic [7:0] shreg;
		logic rw;
		logic first;
		logic ack_phase;
		logic sda_drive;
		logic scl_q;
		logic sda_q;
		logic [7:0] ptr;
		logic wr_stb;
		logic [7:0] wr_addr;
		logic [7:0] wr_data;
	} cfr_i2c_t;

	typedef struct packed {
		logic [`CFR_TMR_W-1:0] cnt;
		logic expired;
	} cfr_timer_t;

endpackage : cfr_pkg

/* File: verilog/cfr_reg_if.sv */
interface cfr_reg_if;
	logic wr_stb;
	logic [7:0] wr_addr;
	logic [7:0] wr_data;
	logic [7:0] rd_addr;
	logic [7:0] rd_data;

	modport serial_end (output wr_stb, output wr_addr, output wr_data, output rd_addr, input rd_data);
	modport regs_end (input wr_stb, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : cfr_reg_if

/* File: verilog/cfr_timer.sv */
`include "cfr_consts.svh"

module cfr_timer (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Control
	input wire logic tick,
	input wire logic run,
	input wire logic clear,
	input wire logic [`CFR_TMR_W-1:0] limit,
	// Status
	output logic expired
);
	cfr_pkg::cfr_timer_t s;
	cfr_pkg::cfr_timer_t n;

	// Millisecond count, holds while stopped, latches on expiry
	always_comb begin
		n = s;
		if (clear) begin
			n.cnt = '0;
			n.expired = 1'b0;
		end else if (run && tick && !s.expired) begin
			if (s.cnt + `CFR_TMR_W'(1) >= limit) begin
				n.expired = 1'b1;
			end else begin
				n.cnt = s.cnt + `CFR_TMR_W'(1);
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign expired = s.expired;
endmodule : cfr_timer
